// File: hdl/spl_params.svh
// Constants of the position capture sequencer: offsets, fields, codes, resets and times.
// Assumes a 25 MHz system clock and 32-bit APB data with one word per register.
`ifndef SPL_PARAMS_SVH
`define SPL_PARAMS_SVH

// Register byte offsets.
`define SPL_OFF_CMD 8'h00
`define SPL_OFF_RESP 8'h04
`define SPL_OFF_STATUS 8'h08
`define SPL_OFF_EXT_STATE 8'h0c
`define SPL_OFF_SEQ_LEN 8'h10
`define SPL_OFF_REPEAT 8'h14
`define SPL_OFF_SRC_LO 8'h18
`define SPL_OFF_SRC_HI 8'h1c
`define SPL_OFF_OPT_SEL_A 8'h20
`define SPL_OFF_OPT_SEL_B 8'h24
`define SPL_OFF_MON_CHOICE 8'h28
`define SPL_OFF_MON1 8'h2c
`define SPL_OFF_MON2 8'h30
`define SPL_OFF_OPT_MON_A 8'h34
`define SPL_OFF_OPT_MON_B 8'h38

// Command word fields.
`define SPL_CMD_CODE_MSB 7
`define SPL_CMD_MODE_BIT 8
`define SPL_CMD_SRC_LSB 16

// Response word fields.
`define SPL_RESP_ACCEPT_BIT 8
`define SPL_RESP_MODE_ERR_BIT 9
`define SPL_RESP_CMD_WARN_BIT 10

// Status and extended state fields.
`define SPL_STATUS_DONE_BIT 10
`define SPL_EXT_STEP_LSB 8
`define SPL_EXT_PASS_LSB 0

// Command codes. Only the release code is fixed; the others are arbitrary values.
`define SPL_CODE_RELEASE 8'h29
`define SPL_CODE_ENTER 8'h01
`define SPL_CODE_SINGLE 8'h02
`define SPL_CODE_HOMING 8'h03
`define SPL_CODE_EXT_POS 8'h04
`define SPL_CODE_SERVO 8'h05

// Mode selector and capture sources.
`define SPL_MODE_CONT 1'b1
`define SPL_SRC_ORIGIN 2'b00
`define SPL_SRC_EXTERNAL_INPUT_ONE 2'b01
`define SPL_SRC_EXTERNAL_INPUT_TWO 2'b10
`define SPL_SRC_EXTERNAL_INPUT_THREE 2'b11
`define SPL_MAX_STEPS 4'h8

// Monitor selection codes.
`define SPL_MON_FEEDBACK 8'h00
`define SPL_MON_CAPTURED 8'h01
`define SPL_OPT_PREVIOUS 8'h80

// Reset values.
`define SPL_RST_SEQ_LEN 4'h0
`define SPL_RST_REPEAT 8'h00
`define SPL_RST_SRC 8'h00
`define SPL_RST_SEL 8'h00

// Timing.
`define SPL_CLK_HZ 64'd25000000
`define SPL_RELEASE_MAX_US 64'd250
`define SPL_RELEASE_MAX_CYC (`SPL_RELEASE_MAX_US * `SPL_CLK_HZ / 64'd1000000)

`endif

// File: hdl/spl_pkg.sv
// Types shared by the position capture sequencer modules.
// Assumes spl_params.svh for the field widths used in the structs.
package spl_pkg;

  typedef enum logic [2:0] {
    SPL_IDLE = 3'b000,
    SPL_NORMAL = 3'b001,
    SPL_CONT = 3'b010,
    SPL_HELD = 3'b011,
    SPL_MOTION = 3'b100
  } spl_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } spl_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } spl_apb_rsp_t;

  typedef struct packed {
    logic [7:0] choice;
    logic [7:0] opt_sel_a;
    logic [7:0] opt_sel_b;
  } spl_mon_sel_t;

  typedef struct packed {
    logic [31:0] mon1;
    logic [31:0] mon2;
    logic [31:0] opt_a;
    logic [31:0] opt_b;
  } spl_mon_out_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } spl_sync_state_t;

  typedef struct packed {
    logic [31:0] latest;
    logic [31:0] previous;
    spl_mon_out_t mon;
  } spl_store_state_t;

  typedef struct packed {
    spl_mode_t mode;
    logic [1:0] src;
    logic [3:0] step;
    logic [7:0] pass;
    logic [3:0] in_prev;
    logic rel_busy;
    logic [12:0] rel_cnt;
    logic [7:0] last_code;
    logic mode_err;
    logic cmd_warn;
    logic done_pend;
    logic done_flag;
    logic [3:0] ext_step;
    logic [7:0] ext_pass;
    logic [3:0] seq_len;
    logic [7:0] repeat_cnt;
    logic [7:0] src_lo;
    logic [7:0] src_hi;
    spl_mon_sel_t sel;
    logic [31:0] prdata;
    logic pslverr;
  } spl_core_state_t;

endpackage

// File: hdl/spl_sync.sv
// Two-stage synchroniser for the four capture source pins.
// Assumes the pins are asynchronous to clock; only the second stage leaves the module.
`timescale 1ns/1ps
`include "spl_params.svh"

module spl_sync (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Pins in, synchronised levels out.
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_sync
);
  import spl_pkg::*;

  spl_sync_state_t st_r;
  spl_sync_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = pin_in;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_sync = st_r.s2;
endmodule

// File: hdl/spl_capture_store.sv
// Holds the latest and the previous captured position and builds the monitor values.
// Assumes capture is a one-cycle pulse and done_flag is the one-communications-cycle flag.
`timescale 1ns/1ps
`include "spl_params.svh"

module spl_capture_store (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Capture event and position.
  input wire logic capture,
  input wire logic [31:0] feedback_position,
  input wire logic done_flag,
  // Monitor selection and results.
  input wire spl_pkg::spl_mon_sel_t sel,
  output spl_pkg::spl_mon_out_t mon,
  output logic [31:0] captured_feedback_position
);
  import spl_pkg::*;

  spl_store_state_t st_r;
  spl_store_state_t st_nxt;

  function automatic logic [31:0] mon_pick(input logic [7:0] code, input logic [31:0] fb,
                                           input logic [31:0] cap);
    mon_pick = (code == `SPL_MON_CAPTURED) ? cap : fb;
  endfunction

  function automatic logic [31:0] opt_pick(input logic [7:0] code, input logic [31:0] prev);
    opt_pick = (code == `SPL_OPT_PREVIOUS) ? prev : 32'h0000_0000;
  endfunction

  always_comb begin
    st_nxt = st_r;
    if (capture) begin
      st_nxt.latest = feedback_position;
      st_nxt.previous = st_r.latest;
    end
    st_nxt.mon.mon1 = mon_pick(sel.choice[7:0], feedback_position, st_r.latest); // [RL9]
    if (done_flag) begin
      st_nxt.mon.mon2 = st_r.latest; // [RL8]
    end else begin
      st_nxt.mon.mon2 = mon_pick(sel.choice[7:0], feedback_position, st_r.latest);
    end
    st_nxt.mon.opt_a = opt_pick(sel.opt_sel_a, st_r.previous); // [RL10]
    st_nxt.mon.opt_b = opt_pick(sel.opt_sel_b, st_r.previous); // [RL10]
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign mon = st_r.mon;
  assign captured_feedback_position = st_r.latest;
endmodule

// File: hdl/spl_sequencer.sv
// Position capture sequencer: APB registers, command decode, normal, continuous and
// motion-command capture, release timing and completion reporting.
// Assumes comm_cycle_tick is a one-cycle pulse from same-clock link logic at each
// communications cycle, and feedback_position is on the same clock.
//
// Notes on behaviour
// RL1: Enter with mode 1 starts continuous capture.
// RL2: Release command aborts a running sequence.
// RL3: Repeat count zero means repeat forever.
// RL4: Mode 1 with length zero: warn, no start.
// RL5: Done flag high one communications cycle each capture.
// RL6: Step number at completion in bits 11:8.
// RL7: Pass count in bits 7:0, bumped on last step.
// RL8: Done flag forces captured position onto monitor two.
// RL9: Latest captured position is a selectable monitor.
// RL10: Option code 80h returns the previous capture.
// RL11: Source selector bits 1:0, upper bits zero.
// RL12: Selector used by motion commands and normal enter.
// RL13: Host assigns external inputs to pins first.
// RL14: Host avoids origin source without origin pulse.
// RL15: Code 29h is release, echoed back.
// RL16: Host waits for accepted bit after release.
// RL17: Release completes within 250 microseconds.
// RL18: Release during motion capture is refused, warned.
// RL19: Step sources from low and high settings.
// RL20: Normal mode captures once, then holds.
// RL21: Continuous mode steps one to n in order.
// RL22: After step n wrap back to step one.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "spl_params.svh"

module spl_sequencer #(
  parameter int unsigned RELEASE_CYC = 32'(`SPL_RELEASE_MAX_CYC)
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // APB slave.
  input wire spl_pkg::spl_apb_req_t apb_req,
  output spl_pkg::spl_apb_rsp_t apb_rsp,
  // Link timing and position.
  input wire logic comm_cycle_tick,
  input wire logic [31:0] feedback_position,
  // Capture source pins.
  input wire logic encoder_origin,
  input wire logic external_input_one,
  input wire logic external_input_two,
  input wire logic external_input_three,
  // Reported state.
  output logic capture_done_flag,
  output logic [15:0] extended_state_field,
  output logic command_accepted_bit,
  output logic [31:0] second_monitor_slot,
  output logic [31:0] captured_feedback_position
);
  import spl_pkg::*;

  spl_core_state_t st_r;
  spl_core_state_t st_nxt;
  logic [3:0] pins_sync;
  logic [3:0] rise;
  logic [1:0] active_src;
  logic capture;
  logic wr_en;
  logic rd_setup;
  logic [7:0] cmd_code;
  logic [3:0] eff_len;
  spl_mon_out_t mon;

  // Sequence step k (1..8) takes two bits from the low setting for 1..4, high for 5..8.
  function automatic logic [1:0] step_source(input logic [7:0] lo, input logic [7:0] hi,
                                             input logic [3:0] step);
    logic [2:0] idx;
    idx = 3'(step - 4'h1);
    if (idx[2]) begin
      step_source = hi[{idx[1:0], 1'b0} +: 2]; // [RL19]
    end else begin
      step_source = lo[{idx[1:0], 1'b0} +: 2]; // [RL19]
    end
  endfunction

  function automatic logic is_motion_code(input logic [7:0] code);
    is_motion_code = (code == `SPL_CODE_SINGLE) || (code == `SPL_CODE_HOMING) ||
                     (code == `SPL_CODE_EXT_POS) || (code == `SPL_CODE_SERVO);
  endfunction

  spl_sync u_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .pin_in({external_input_three, external_input_two, external_input_one, encoder_origin}),
    .pin_sync(pins_sync)
  );

  spl_capture_store u_store (
    .clock(clock),
    .sys_rst(sys_rst),
    .capture(capture),
    .feedback_position(feedback_position),
    .done_flag(st_r.done_flag),
    .sel(st_r.sel),
    .mon(mon),
    .captured_feedback_position(captured_feedback_position)
  );

  assign rise = pins_sync & ~st_r.in_prev;
  assign wr_en = apb_req.psel && apb_req.penable && apb_req.pwrite;
  assign rd_setup = apb_req.psel && !apb_req.penable;
  assign cmd_code = apb_req.pwdata[`SPL_CMD_CODE_MSB:0];
  assign eff_len = (st_r.seq_len > `SPL_MAX_STEPS) ? `SPL_MAX_STEPS : st_r.seq_len;

  always_comb begin
    if (st_r.mode == SPL_CONT) begin
      active_src = step_source(st_r.src_lo, st_r.src_hi, st_r.step); // [RL21]
    end else begin
      active_src = st_r.src; // [RL12]
    end
  end

  assign capture = ((st_r.mode == SPL_NORMAL) || (st_r.mode == SPL_CONT) ||
                    (st_r.mode == SPL_MOTION)) && !st_r.rel_busy && rise[active_src];

  always_comb begin
    st_nxt = st_r;
    st_nxt.in_prev = pins_sync;

    // Capture progress.
    if (capture) begin
      st_nxt.done_pend = 1'b1;
      st_nxt.ext_step = st_r.step; // [RL6]
      case (st_r.mode)
        SPL_NORMAL: begin
          st_nxt.mode = SPL_HELD; // [RL20]
        end
        SPL_MOTION: begin
          st_nxt.mode = SPL_IDLE;
        end
        SPL_CONT: begin
          if (st_r.step >= eff_len) begin
            st_nxt.step = 4'h1; // [RL22]
            st_nxt.pass = st_r.pass + 8'h01; // [RL7]
            st_nxt.ext_pass = st_r.pass + 8'h01; // [RL7]
            if ((st_r.repeat_cnt != 8'h00) && (st_r.pass + 8'h01 >= st_r.repeat_cnt)) begin
              st_nxt.mode = SPL_HELD;
            end
            // A zero repeat count never reaches the stop above. [RL3]
          end else begin
            st_nxt.step = st_r.step + 4'h1; // [RL21]
          end
        end
        default: begin
          st_nxt.mode = st_r.mode;
        end
      endcase
    end

    // Done flag spans one communications cycle; a capture in the tick cycle stays pending.
    if (comm_cycle_tick) begin
      st_nxt.done_flag = st_r.done_pend; // [RL5]
      st_nxt.done_pend = capture;
    end

    // Release in progress ends within the allowed time.
    if (st_r.rel_busy) begin
      if (st_r.rel_cnt == 13'h0000) begin
        st_nxt.rel_busy = 1'b0; // [RL17]
        st_nxt.mode = SPL_IDLE; // [RL2]
        st_nxt.step = 4'h1;
        st_nxt.pass = 8'h00;
      end else begin
        st_nxt.rel_cnt = st_r.rel_cnt - 13'h0001; // [RL17]
      end
    end

    // Register writes and commands.
    if (wr_en) begin
      case (apb_req.paddr)
        `SPL_OFF_CMD: begin
          st_nxt.last_code = cmd_code; // [RL15]
          if (cmd_code == `SPL_CODE_RELEASE) begin
            if (st_r.mode == SPL_MOTION) begin
              st_nxt.cmd_warn = 1'b1; // [RL18]
            end else if (!st_r.rel_busy) begin
              st_nxt.rel_busy = 1'b1; // [RL2]
              st_nxt.mode = SPL_IDLE; // [RL2]
              st_nxt.rel_cnt = 13'(RELEASE_CYC - 32'd1); // [RL17]
            end
          end else if (!st_r.rel_busy && st_r.mode == SPL_IDLE) begin
            if (cmd_code == `SPL_CODE_ENTER) begin
              if (apb_req.pwdata[`SPL_CMD_MODE_BIT] == `SPL_MODE_CONT) begin
                if (st_r.seq_len == 4'h0) begin
                  st_nxt.mode_err = 1'b1; // [RL4]
                end else begin
                  st_nxt.mode = SPL_CONT; // [RL1]
                  st_nxt.step = 4'h1; // [RL21]
                  st_nxt.pass = 8'h00;
                  st_nxt.ext_pass = 8'h00;
                end
              end else begin
                st_nxt.mode = SPL_NORMAL; // [RL20]
                st_nxt.src = apb_req.pwdata[`SPL_CMD_SRC_LSB +: 2]; // [RL11] [RL12]
                st_nxt.step = 4'h0;
              end
            end else if (is_motion_code(cmd_code)) begin
              st_nxt.mode = SPL_MOTION;
              st_nxt.src = apb_req.pwdata[`SPL_CMD_SRC_LSB +: 2]; // [RL12]
              st_nxt.step = 4'h0;
            end
          end
        end
        `SPL_OFF_RESP: begin
          // Write one clears a warning; warnings are only set by command writes.
          if (apb_req.pwdata[`SPL_RESP_MODE_ERR_BIT]) begin
            st_nxt.mode_err = 1'b0;
          end
          if (apb_req.pwdata[`SPL_RESP_CMD_WARN_BIT]) begin
            st_nxt.cmd_warn = 1'b0;
          end
        end
        `SPL_OFF_SEQ_LEN: begin
          st_nxt.seq_len = apb_req.pwdata[3:0];
        end
        `SPL_OFF_REPEAT: begin
          st_nxt.repeat_cnt = apb_req.pwdata[7:0];
        end
        `SPL_OFF_SRC_LO: begin
          st_nxt.src_lo = apb_req.pwdata[7:0]; // [RL19]
        end
        `SPL_OFF_SRC_HI: begin
          st_nxt.src_hi = apb_req.pwdata[7:0]; // [RL19]
        end
        `SPL_OFF_OPT_SEL_A: begin
          st_nxt.sel.opt_sel_a = apb_req.pwdata[7:0];
        end
        `SPL_OFF_OPT_SEL_B: begin
          st_nxt.sel.opt_sel_b = apb_req.pwdata[7:0];
        end
        `SPL_OFF_MON_CHOICE: begin
          st_nxt.sel.choice = apb_req.pwdata[7:0];
        end
        default: begin
          st_nxt.sel = st_nxt.sel;
        end
      endcase
    end

    // Read data and error are captured in the setup cycle for the access cycle.
    if (rd_setup) begin
      st_nxt.pslverr = 1'b0;
      st_nxt.prdata = 32'h0000_0000;
      case (apb_req.paddr)
        `SPL_OFF_CMD: begin
          st_nxt.prdata = 32'h0000_0000;
        end
        `SPL_OFF_RESP: begin
          st_nxt.prdata[7:0] = st_r.last_code; // [RL15]
          st_nxt.prdata[`SPL_RESP_ACCEPT_BIT] = !st_r.rel_busy;
          st_nxt.prdata[`SPL_RESP_MODE_ERR_BIT] = st_r.mode_err;
          st_nxt.prdata[`SPL_RESP_CMD_WARN_BIT] = st_r.cmd_warn;
        end
        `SPL_OFF_STATUS: begin
          st_nxt.prdata[`SPL_STATUS_DONE_BIT] = st_r.done_flag; // [RL5]
        end
        `SPL_OFF_EXT_STATE: begin
          st_nxt.prdata[11:0] = {st_r.ext_step, st_r.ext_pass}; // [RL6] [RL7]
        end
        `SPL_OFF_SEQ_LEN: begin
          st_nxt.prdata[3:0] = st_r.seq_len;
        end
        `SPL_OFF_REPEAT: begin
          st_nxt.prdata[7:0] = st_r.repeat_cnt;
        end
        `SPL_OFF_SRC_LO: begin
          st_nxt.prdata[7:0] = st_r.src_lo;
        end
        `SPL_OFF_SRC_HI: begin
          st_nxt.prdata[7:0] = st_r.src_hi;
        end
        `SPL_OFF_OPT_SEL_A: begin
          st_nxt.prdata[7:0] = st_r.sel.opt_sel_a;
        end
        `SPL_OFF_OPT_SEL_B: begin
          st_nxt.prdata[7:0] = st_r.sel.opt_sel_b;
        end
        `SPL_OFF_MON_CHOICE: begin
          st_nxt.prdata[7:0] = st_r.sel.choice;
        end
        `SPL_OFF_MON1: begin
          st_nxt.prdata = mon.mon1; // [RL9]
        end
        `SPL_OFF_MON2: begin
          st_nxt.prdata = mon.mon2; // [RL8]
        end
        `SPL_OFF_OPT_MON_A: begin
          st_nxt.prdata = mon.opt_a; // [RL10]
        end
        `SPL_OFF_OPT_MON_B: begin
          st_nxt.prdata = mon.opt_b; // [RL10]
        end
        default: begin
          st_nxt.pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
      st_r.mode <= SPL_IDLE;
      st_r.step <= 4'h1;
      st_r.seq_len <= `SPL_RST_SEQ_LEN;
      st_r.repeat_cnt <= `SPL_RST_REPEAT;
      st_r.src_lo <= `SPL_RST_SRC;
      st_r.src_hi <= `SPL_RST_SRC;
      st_r.sel <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign apb_rsp.prdata = st_r.prdata;
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = st_r.pslverr && apb_req.psel && apb_req.penable;
  assign capture_done_flag = st_r.done_flag;
  assign extended_state_field = {4'h0, st_r.ext_step, st_r.ext_pass};
  assign command_accepted_bit = !st_r.rel_busy;
  assign second_monitor_slot = mon.mon2;
endmodule

// File: sim/spl_link_model.sv
// Host side of the cyclic link: marks each communications cycle with a one-clock tick.
// Assumes one host cycle lasts PERIOD system clocks.
`timescale 1ns/1ps

module spl_link_model #(
  parameter int PERIOD = 16
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic sys_rst,
  // Cycle marker.
  output logic comm_cycle_tick
);
  int cnt;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 0;
      comm_cycle_tick <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      comm_cycle_tick <= (cnt == PERIOD - 1);
    end
  end
endmodule

// File: sim/spl_sequencer_sva.sv
// Port checker for the position capture sequencer.
// Assumes it is bound to spl_sequencer and given the same RELEASE_CYC.
`timescale 1ns/1ps

module spl_sequencer_sva #(
  parameter int unsigned RELEASE_CYC = 8
) (
  // Clock, reset and bus.
  input wire logic clock,
  input wire logic sys_rst,
  input wire spl_pkg::spl_apb_req_t apb_req,
  input wire spl_pkg::spl_apb_rsp_t apb_rsp,
  // Link and reported state.
  input wire logic comm_cycle_tick,
  input wire logic capture_done_flag,
  input wire logic [15:0] extended_state_field,
  input wire logic command_accepted_bit,
  input wire logic [31:0] second_monitor_slot,
  input wire logic [31:0] captured_feedback_position
);
  import spl_pkg::*;
  localparam int REL_MAX = RELEASE_CYC + 2;
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_access;
    apb_req.psel && apb_req.penable;
  endsequence

  sequence s_bad_read;
    s_access ##0 (!apb_req.pwrite && apb_req.paddr > 8'h38);
  endsequence

  chk_ready_in_access: assert property (s_access |-> apb_rsp.pready)
    else $error("pready low in access");
  chk_unmapped_error: assert property (s_bad_read |-> apb_rsp.pslverr)
    else $error("no error on unmapped read");
  chk_error_idle: assert property (!apb_req.psel |-> !apb_rsp.pslverr)
    else $error("error outside a transfer");
  chk_done_at_tick: assert property ($rose(capture_done_flag) |-> $past(comm_cycle_tick))
    else $error("done flag rose off a tick");
  chk_done_stands: assert property (capture_done_flag && !comm_cycle_tick |=>
    capture_done_flag)
    else $error("done flag dropped inside a cycle");
  chk_mon_forced: assert property (capture_done_flag |=>
    second_monitor_slot == $past(captured_feedback_position))
    else $error("monitor two not forced");
  chk_ext_top_zero: assert property (extended_state_field[15:12] == 4'h0)
    else $error("extended state top bits set");
  chk_release_bound: assert property ($fell(command_accepted_bit) |->
    ##[1:REL_MAX] command_accepted_bit)
    else $error("release took too long");
endmodule

bind spl_sequencer spl_sequencer_sva #(.RELEASE_CYC(RELEASE_CYC)) u_sva (
  .clock(clock),
  .sys_rst(sys_rst),
  .apb_req(apb_req),
  .apb_rsp(apb_rsp),
  .comm_cycle_tick(comm_cycle_tick),
  .capture_done_flag(capture_done_flag),
  .extended_state_field(extended_state_field),
  .command_accepted_bit(command_accepted_bit),
  .second_monitor_slot(second_monitor_slot),
  .captured_feedback_position(captured_feedback_position)
);

// File: sim/test_servo_position_latch_sequencer.sv
// Self-checking bench for the position capture sequencer.
// Assumes spl_link_model supplies the tick and the bench plays the host over APB.
`timescale 1ns/1ps
`include "spl_params.svh"

module test_servo_position_latch_sequencer;
  import spl_pkg::*;
  localparam int REL = 8;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  spl_apb_req_t req = '0;
  spl_apb_rsp_t rsp;
  logic tick, done, acc, err;
  logic [31:0] fpos = 32'h0;
  logic [3:0] pins = 4'h0;
  logic [15:0] ext;
  logic [31:0] cap, q, prev, last, mon2;
  logic [31:0] seed = 32'h65e83747;
  int bad_count = 0;
  int samples_checked = 0;

  always #20 clock = ~clock;

  spl_link_model #(.PERIOD(16)) u_link (.clock(clock), .sys_rst(sys_rst), .comm_cycle_tick(tick));
  spl_sequencer #(.RELEASE_CYC(REL)) u_dut (.clock(clock), .sys_rst(sys_rst), .apb_req(req),
    .apb_rsp(rsp), .comm_cycle_tick(tick), .feedback_position(fpos), .encoder_origin(pins[0]),
    .external_input_one(pins[1]), .external_input_two(pins[2]), .external_input_three(pins[3]),
    .capture_done_flag(done), .extended_state_field(ext), .command_accepted_bit(acc),
    .second_monitor_slot(mon2), .captured_feedback_position(cap));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Source of step k, taken from the low or the high step setting.
  function automatic int src_of(input logic [7:0] lo, input logic [7:0] hi, input int k);
    logic [15:0] w;
    w = {hi, lo};
    return int'(w[2*k +: 2]);
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic cmd(input logic [7:0] code, input logic mode, input logic [1:0] src);
    apb(1'b1, 8'h00, {14'h0, src, 7'h0, mode, code});
  endtask

  // Pulses one pin at a fresh position and checks whether it was captured.
  task automatic hit(input int p, input logic exp);
    int n;
    seed = lfsr(seed);
    fpos <= seed;
    @(posedge clock);
    pins[p] <= 1'b1;
    repeat (6) @(posedge clock);
    pins[p] <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 40) begin
      @(posedge clock);
      n++;
    end
    chk({31'h0, done}, {31'h0, exp});
    if (exp) begin
      @(posedge clock);
      chk(mon2, seed);
    end
    chk(cap, exp ? seed : last);
    if (exp) begin
      prev = last;
      last = seed;
    end
    repeat (20) @(posedge clock);
  endtask

  // The host waits for the accepted bit before moving on.
  task automatic rel();
    int n;
    cmd(8'h29, 1'b0, 2'b00);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (acc !== 1'b1 && n < 50);
    chk({31'h0, n > 1 && n <= REL + 2}, 32'h1);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h129);
  endtask

  task automatic cont(input logic [3:0] len, input logic [7:0] m, input logic [7:0] lo,
      input logic [7:0] hi, input int passes);
    apb(1'b1, 8'h10, {28'h0, len});
    apb(1'b1, 8'h14, {24'h0, m});
    apb(1'b1, 8'h18, {24'h0, lo});
    apb(1'b1, 8'h1c, {24'h0, hi});
    cmd(8'h01, 1'b1, 2'b00);
    hit((src_of(lo, hi, 0) + 1) % 4, 1'b0);
    for (int p = 1; p <= passes; p++) begin
      for (int k = 0; k < len; k++) begin
        hit(src_of(lo, hi, k), 1'b1);
        chk({16'h0, ext}, {20'h0, 4'(k + 1), 8'(k == len - 1 ? p : p - 1)});
      end
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    last = 32'h0;
    prev = 32'h0;
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h100);
    apb(1'b0, 8'h3c, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int i = 0; i < 7; i++) begin
      seed = lfsr(seed);
      apb(1'b0, 8'h10 + 8'(4 * i), 32'h0);
      chk(q, 32'h0);
      apb(1'b1, 8'h10 + 8'(4 * i), seed);
      apb(1'b0, 8'h10 + 8'(4 * i), 32'h0);
      chk(q, seed & (i == 0 ? 32'hf : 32'hff));
    end
    apb(1'b1, 8'h10, 32'h0);
    cmd(8'h01, 1'b1, 2'b01);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h301);
    hit(1, 1'b0);
    apb(1'b1, 8'h04, 32'h200);
    // Every source has its pin wired, the origin pulse included.
    for (int s = 0; s < 4; s++) begin
      rel();
      cmd(8'h01, 1'b0, 2'(s));
      hit((s + 1) % 4, 1'b0);
      hit(s, 1'b1);
      hit(s, 1'b0);
    end
    apb(1'b1, 8'h20, 32'h80);
    apb(1'b1, 8'h28, 32'h1);
    apb(1'b0, 8'h34, 32'h0);
    chk(q, prev);
    apb(1'b0, 8'h2c, 32'h0);
    chk(q, last);
    for (int c = 2; c < 6; c++) begin
      rel();
      cmd(8'(c), 1'b0, 2'b11);
      cmd(8'h29, 1'b0, 2'b00);
      apb(1'b0, 8'h04, 32'h0);
      chk(q, 32'h529);
      hit(3, 1'b1);
      apb(1'b1, 8'h04, 32'h400);
    end
    rel();
    cont(4'h2, 8'h2, 8'h09, 8'h00, 2);
    hit(1, 1'b0);
    rel();
    cont(4'h5, 8'h0, seed[7:0], seed[15:8], 2);
    rel();
    for (int s = 0; s < 4; s++) begin
      hit(s, 1'b0);
    end
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clock);
    bad_count++;
    finish_test();
  end
endmodule
